// ### include/shc_pkg.sv
package shc_pkg;

  // timing: clock and the post-reset wait figures
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned RESET_PRESCALE    = 512;
  localparam int unsigned RESET_WAIT_PULSES = 256;
  // stabilisation depends on the resonator; this default is a plain guess
  localparam int unsigned OSC_STAB_TIME_NS  = 2000000;
  localparam int unsigned OSC_STAB_CYCLES   =
    (OSC_STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter widths
  localparam int unsigned PRE_W  = 10;
  localparam int unsigned PULS_W = 9;
  localparam int unsigned OSC_W  = 20;

  // program addresses
  localparam int unsigned PC_W = 12;
  localparam logic [11:0] RESET_ADDR = 12'h000;
  localparam logic [11:0] VEC_EXT    = 12'h005;
  localparam logic [11:0] VEC_TIMER0 = 12'h004;
  localparam logic [11:0] VEC_TIMER1 = 12'h003;
  localparam logic [11:0] VEC_BASIC  = 12'h002;
  localparam logic [11:0] VEC_SERIAL = 12'h001;

  // request bit positions, highest priority in the top bit
  localparam int unsigned SRC_N      = 5;
  localparam int unsigned SRC_EXT    = 4;
  localparam int unsigned SRC_TIMER0 = 3;
  localparam int unsigned SRC_TIMER1 = 2;
  localparam int unsigned SRC_BASIC  = 1;
  localparam int unsigned SRC_SERIAL = 0;

  // operand field positions
  localparam int unsigned OP_IRQ_BIT = 3;
  localparam int unsigned OP_T1_BIT  = 1;
  localparam logic [3:0]  OP_NONE    = 4'h0;

  typedef enum logic [2:0] {
    ST_RESET_WAIT,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_STOP_CLEAR,
    ST_OSC_WAIT
  } shc_state_e;

  typedef enum logic [1:0] {
    RES_RESET,
    RES_SEQUENTIAL,
    RES_VECTOR
  } shc_resume_e;

  // instruction decoder strobes
  typedef struct packed {
    logic        valid;
    logic        halt;
    logic        stop;
    logic        ei;
    logic        di;
    logic [3:0]  operand;
    logic [11:0] next_addr;
  } shc_instr_s;

  // peripheral run controls
  typedef struct packed {
    logic timer0_run;
    logic timer1_run;
    logic timer1_clear;
    logic basic_timer_run;
    logic serial_run;
    logic adc_run;
    logic adc_result_clear;
  } shc_periph_s;

  // resume answer towards the cpu
  typedef struct packed {
    logic              valid;
    shc_resume_e       kind;
    logic [11:0]       addr;
    logic [SRC_N-1:0]  vector_source;
  } shc_resume_s;

endpackage

// ### logic/shc_tick_counter.sv
`timescale 1ns/100ps
`default_nettype none

// free counter that wraps at limit and pulses done on the wrapping tick
module shc_tick_counter #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] count;
  } shc_cnt_s;

  shc_cnt_s cnt_reg;
  shc_cnt_s cnt_next;

  // clear dominates so a leftover count never shortens the next wait
  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next.count = '0;
    end else if (enable) begin
      if (cnt_reg.count == limit) begin
        cnt_next.count = '0;
      end else begin
        cnt_next.count = cnt_reg.count + 1'b1;
      end
    end
  end

  assign done = enable && !clear && (cnt_reg.count == limit);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // shc_tick_counter

`default_nettype wire

// ### logic/shc_standby_controller.sv
`timescale 1ns/100ps
`default_nettype none

module shc_standby_controller #(
  parameter int unsigned PRESCALE_DIV    = shc_pkg::RESET_PRESCALE,
  parameter int unsigned WAIT_PULSES     = shc_pkg::RESET_WAIT_PULSES,
  parameter int unsigned OSC_STAB_CYCLES = shc_pkg::OSC_STAB_CYCLES
) (
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  input  wire shc_pkg::shc_instr_s          instr,
  input  wire logic [shc_pkg::SRC_N-1:0]    interrupt_request_flag,
  input  wire logic [shc_pkg::SRC_N-1:0]    source_interrupt_enable,
  input  wire logic                         timer0_src_is_pin,
  input  wire logic                         serial_ext_clock,
  output logic                              osc_enable,
  output logic                              cpu_clock_enable,
  output logic                              state_hold,
  output logic                              soft_reset_req,
  output logic                              pins_force_input,
  output logic                              global_interrupt_enable,
  output logic                              instr_ignored,
  output shc_pkg::shc_periph_s              periph,
  output shc_pkg::shc_resume_s              resume
);

  // whole controller state
  typedef struct packed {
    shc_pkg::shc_state_e  state;
    logic [3:0]           operand;
    logic [11:0]          next_addr;
    logic                 gie;
    logic                 ignored;
    shc_pkg::shc_resume_s resume;
  } shc_ctrl_s;

  shc_ctrl_s ctl_reg;
  shc_ctrl_s ctl_next;

  logic                      pre_tick;
  logic                      reset_wait_done;
  logic                      osc_wait_done;
  logic                      in_reset_wait;
  logic                      in_osc_wait;
  logic                      stopped;
  logic [shc_pkg::SRC_N-1:0] enabled_req;
  logic                      any_req;
  logic                      any_enabled;
  logic                      halt_release;
  logic                      stop_release;
  logic                      take_halt;
  logic                      take_stop;

  localparam logic [shc_pkg::PRE_W-1:0]  PRE_LIMIT  =
    shc_pkg::PRE_W'(PRESCALE_DIV - 1);
  localparam logic [shc_pkg::PULS_W-1:0] PULS_LIMIT =
    shc_pkg::PULS_W'(WAIT_PULSES - 1);
  localparam logic [shc_pkg::OSC_W-1:0]  OSC_LIMIT  =
    shc_pkg::OSC_W'(OSC_STAB_CYCLES - 1);

  // highest-priority enabled source, empty vector if none
  function automatic logic [shc_pkg::SRC_N-1:0] pick_top(
    input logic [shc_pkg::SRC_N-1:0] req
  );
    logic [shc_pkg::SRC_N-1:0] one;
    one = '0;
    if (req[shc_pkg::SRC_EXT]) begin
      one[shc_pkg::SRC_EXT] = 1'b1;
    end else if (req[shc_pkg::SRC_TIMER0]) begin
      one[shc_pkg::SRC_TIMER0] = 1'b1;
    end else if (req[shc_pkg::SRC_TIMER1]) begin
      one[shc_pkg::SRC_TIMER1] = 1'b1;
    end else if (req[shc_pkg::SRC_BASIC]) begin
      one[shc_pkg::SRC_BASIC] = 1'b1;
    end else if (req[shc_pkg::SRC_SERIAL]) begin
      one[shc_pkg::SRC_SERIAL] = 1'b1;
    end
    return one;
  endfunction

  // vector address of a one-hot source
  function automatic logic [11:0] vector_of(
    input logic [shc_pkg::SRC_N-1:0] one
  );
    logic [11:0] addr;
    addr = shc_pkg::RESET_ADDR;
    if (one[shc_pkg::SRC_EXT]) begin
      addr = shc_pkg::VEC_EXT;
    end else if (one[shc_pkg::SRC_TIMER0]) begin
      addr = shc_pkg::VEC_TIMER0;
    end else if (one[shc_pkg::SRC_TIMER1]) begin
      addr = shc_pkg::VEC_TIMER1;
    end else if (one[shc_pkg::SRC_BASIC]) begin
      addr = shc_pkg::VEC_BASIC;
    end else if (one[shc_pkg::SRC_SERIAL]) begin
      addr = shc_pkg::VEC_SERIAL;
    end
    return addr;
  endfunction

  // status decode
  assign in_reset_wait = (ctl_reg.state == shc_pkg::ST_RESET_WAIT);
  assign in_osc_wait   = (ctl_reg.state == shc_pkg::ST_OSC_WAIT);
  assign stopped       = (ctl_reg.state == shc_pkg::ST_STOP)
                      || (ctl_reg.state == shc_pkg::ST_STOP_CLEAR)
                      || in_osc_wait;

  // request qualification
  assign enabled_req = interrupt_request_flag & source_interrupt_enable;
  assign any_req     = |interrupt_request_flag;
  assign any_enabled = |enabled_req;

  // halt release: enabled request or forced timer-one release
  assign halt_release =
    (ctl_reg.operand[shc_pkg::OP_IRQ_BIT] && any_enabled)
    || (ctl_reg.operand[shc_pkg::OP_T1_BIT]
        && interrupt_request_flag[shc_pkg::SRC_TIMER1]);

  // stop release ignores the timer-one forced path
  assign stop_release =
    ctl_reg.operand[shc_pkg::OP_IRQ_BIT] && any_enabled;

  // a pending request turns the instruction into a nop; this also
  // covers the narrower enabled-and-selected case
  assign take_halt = instr.valid && instr.halt && !any_req;
  assign take_stop = instr.valid && instr.stop && !any_req;

  // prescaler for the post-reset wait, a timer-one style divider
  shc_tick_counter #(
    .W (shc_pkg::PRE_W)
  ) u_prescale (
    .clock  (clock),
    .rst_b  (rst_b),
    .clear  (!in_reset_wait),
    .enable (in_reset_wait),
    .limit  (PRE_LIMIT),
    .done   (pre_tick)
  );

  // count of divided pulses during the post-reset wait
  shc_tick_counter #(
    .W (shc_pkg::PULS_W)
  ) u_reset_wait (
    .clock  (clock),
    .rst_b  (rst_b),
    .clear  (!in_reset_wait),
    .enable (pre_tick),
    .limit  (PULS_LIMIT),
    .done   (reset_wait_done)
  );

  // oscillator settling time after a stop wake
  shc_tick_counter #(
    .W (shc_pkg::OSC_W)
  ) u_osc_wait (
    .clock  (clock),
    .rst_b  (rst_b),
    .clear  (!in_osc_wait),
    .enable (in_osc_wait),
    .limit  (OSC_LIMIT),
    .done   (osc_wait_done)
  );

  // next-state logic; resume valid and vector_source are one-cycle pulses
  always_comb begin
    ctl_next               = ctl_reg;
    ctl_next.ignored       = 1'b0;
    ctl_next.resume.valid  = 1'b0;
    ctl_next.resume.vector_source = '0;

    // di wins if both arrive together, the safer outcome
    if (instr.valid && instr.di) begin
      ctl_next.gie = 1'b0;
    end else if (instr.valid && instr.ei) begin
      ctl_next.gie = 1'b1;
    end

    case (ctl_reg.state)
      shc_pkg::ST_RESET_WAIT: begin
        // cpu held until the divided count completes
        if (reset_wait_done) begin
          ctl_next.state       = shc_pkg::ST_RUN;
          ctl_next.resume.valid = 1'b1;
          ctl_next.resume.kind = shc_pkg::RES_RESET;
          ctl_next.resume.addr = shc_pkg::RESET_ADDR;
        end
      end
      shc_pkg::ST_RUN: begin
        if (instr.valid && (instr.halt || instr.stop) && any_req) begin
          ctl_next.ignored = 1'b1;
        end else if (take_halt) begin
          ctl_next.state     = shc_pkg::ST_HALT;
          ctl_next.operand   = instr.operand;
          ctl_next.next_addr = instr.next_addr;
        end else if (take_stop) begin
          ctl_next.operand   = instr.operand;
          ctl_next.next_addr = instr.next_addr;
          if (instr.operand == shc_pkg::OP_NONE) begin
            ctl_next.state = shc_pkg::ST_STOP_CLEAR;
          end else begin
            ctl_next.state = shc_pkg::ST_STOP;
          end
        end
      end
      shc_pkg::ST_HALT: begin
        // an all-zero operand never releases; only rst_b does
        if (halt_release) begin
          ctl_next.state        = shc_pkg::ST_RUN;
          ctl_next.resume.valid = 1'b1;
          if (ctl_reg.gie && any_enabled) begin
            ctl_next.resume.kind = shc_pkg::RES_VECTOR;
            ctl_next.resume.vector_source = pick_top(enabled_req);
            ctl_next.resume.addr = vector_of(pick_top(enabled_req));
          end else begin
            ctl_next.resume.kind = shc_pkg::RES_SEQUENTIAL;
            ctl_next.resume.addr = ctl_reg.next_addr;
          end
        end
      end
      shc_pkg::ST_STOP: begin
        if (stop_release) begin
          ctl_next.state = shc_pkg::ST_OSC_WAIT;
        end
      end
      shc_pkg::ST_STOP_CLEAR: begin
        // parked until rst_b; the rest of the chip is reinitialised
        ctl_next.state = shc_pkg::ST_STOP_CLEAR;
      end
      shc_pkg::ST_OSC_WAIT: begin
        // decision taken after settling, on the flags then present
        if (osc_wait_done) begin
          ctl_next.state        = shc_pkg::ST_RUN;
          ctl_next.resume.valid = 1'b1;
          if (ctl_reg.gie && any_enabled) begin
            ctl_next.resume.kind = shc_pkg::RES_VECTOR;
            ctl_next.resume.vector_source = pick_top(enabled_req);
            ctl_next.resume.addr = vector_of(pick_top(enabled_req));
          end else begin
            ctl_next.resume.kind = shc_pkg::RES_SEQUENTIAL;
            ctl_next.resume.addr = ctl_reg.next_addr;
          end
        end
      end
      default: begin
        ctl_next.state = shc_pkg::ST_RESET_WAIT;
      end
    endcase
  end

  // state register; every reset starts in the post-reset wait
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctl_reg.state         <= shc_pkg::ST_RESET_WAIT;
      ctl_reg.operand       <= shc_pkg::OP_NONE;
      ctl_reg.next_addr     <= shc_pkg::RESET_ADDR;
      ctl_reg.gie           <= 1'b0;
      ctl_reg.ignored       <= 1'b0;
      ctl_reg.resume.valid  <= 1'b0;
      ctl_reg.resume.kind   <= shc_pkg::RES_RESET;
      ctl_reg.resume.addr   <= shc_pkg::RESET_ADDR;
      ctl_reg.resume.vector_source <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // clock controls
  assign osc_enable = (ctl_reg.state != shc_pkg::ST_STOP)
                   && (ctl_reg.state != shc_pkg::ST_STOP_CLEAR);
  assign cpu_clock_enable = (ctl_reg.state == shc_pkg::ST_RUN);

  // retention: cpu state frozen in halt and stop, not in stop zero
  assign state_hold = (ctl_reg.state == shc_pkg::ST_HALT)
                   || (ctl_reg.state == shc_pkg::ST_STOP)
                   || in_osc_wait;
  assign soft_reset_req   = (ctl_reg.state == shc_pkg::ST_STOP_CLEAR);
  assign pins_force_input = (ctl_reg.state == shc_pkg::ST_STOP_CLEAR);

  // peripheral controls; in halt everything keeps running
  assign periph.timer0_run       = !stopped || timer0_src_is_pin;
  assign periph.timer1_run       = !stopped;
  assign periph.timer1_clear     = stopped;
  assign periph.basic_timer_run  = !stopped;
  assign periph.serial_run       = !stopped || serial_ext_clock;
  assign periph.adc_run          = !stopped;
  assign periph.adc_result_clear = stopped;

  // registered answers
  assign global_interrupt_enable = ctl_reg.gie;
  assign instr_ignored           = ctl_reg.ignored;
  assign resume                  = ctl_reg.resume;

endmodule // shc_standby_controller

`default_nettype wire

// ### tb/shc_standby_assertions.sv
`timescale 1ns/100ps
`default_nettype none

// watches the standby controller from its ports only
module shc_standby_assertions #(
  parameter int unsigned PRESCALE_DIV    = 4,
  parameter int unsigned WAIT_PULSES     = 4,
  parameter int unsigned OSC_STAB_CYCLES = 8
) (
  input wire logic                      clock,
  input wire logic                      rst_b,
  input wire shc_pkg::shc_instr_s       instr,
  input wire logic [shc_pkg::SRC_N-1:0] interrupt_request_flag,
  input wire logic [shc_pkg::SRC_N-1:0] source_interrupt_enable,
  input wire logic                      timer0_src_is_pin,
  input wire logic                      serial_ext_clock,
  input wire logic                      osc_enable,
  input wire logic                      cpu_clock_enable,
  input wire logic                      state_hold,
  input wire logic                      soft_reset_req,
  input wire logic                      pins_force_input,
  input wire logic                      global_interrupt_enable,
  input wire logic                      instr_ignored,
  input wire shc_pkg::shc_periph_s      periph,
  input wire shc_pkg::shc_resume_s      resume
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic [11:0] vec_addr;
  logic        run_cmd;

  // vector implied by the one-hot source: bit i lands on address i+1
  always_comb begin
    vec_addr = 12'h000;
    for (int i = 0; i < 5; i++) begin
      if (resume.vector_source[i]) vec_addr = 12'(i + 1);
    end
  end
  // a standby command is only taken while the cpu clock runs
  assign run_cmd = cpu_clock_enable && instr.valid && (instr.halt || instr.stop);

  sequence boot_seq;
    (!cpu_clock_enable)[*8] ##[1:40] (resume.valid && resume.addr == 12'h000 && cpu_clock_enable);
  endsequence
  sequence settle_seq;
    state_hold[*7] ##[1:4] (resume.valid && cpu_clock_enable);
  endsequence

  halt_entry_a: assert property (run_cmd && instr.halt && interrupt_request_flag == 5'h00
    |=> !cpu_clock_enable && osc_enable && state_hold) else $error("halt entry wrong");
  stop_entry_a: assert property (run_cmd && instr.stop && interrupt_request_flag == 5'h00
    |=> !osc_enable && !cpu_clock_enable) else $error("stop entry wrong");
  pending_nop_a: assert property (run_cmd && interrupt_request_flag != 5'h00
    |=> instr_ignored && cpu_clock_enable) else $error("pending request not a nop");
  stop_periph_a: assert property (!osc_enable |-> periph.timer1_clear && !periph.timer1_run
    && !periph.basic_timer_run && !periph.adc_run && periph.adc_result_clear)
    else $error("peripheral not stopped");
  timer0_stop_a: assert property (!osc_enable
    |-> periph.timer0_run == timer0_src_is_pin) else $error("timer zero run wrong");
  serial_stop_a: assert property (!osc_enable
    |-> periph.serial_run == serial_ext_clock) else $error("serial run wrong");
  zero_park_a: assert property (soft_reset_req
    |-> pins_force_input && !osc_enable) else $error("stop zero park wrong");
  di_clear_a: assert property (instr.valid && instr.di
    |=> !global_interrupt_enable) else $error("global enable not cleared");
  ei_set_a: assert property (instr.valid && instr.ei && !instr.di
    |=> global_interrupt_enable) else $error("global enable not set");
  vector_addr_a: assert property (resume.valid && resume.kind == shc_pkg::RES_VECTOR
    |-> $onehot(resume.vector_source) && resume.addr == vec_addr) else $error("vector address wrong");
  reset_wait_a: assert property ($rose(rst_b) |-> boot_seq)
    else $error("reset wait wrong");
  osc_settle_a: assert property ($rose(osc_enable) |-> settle_seq)
    else $error("oscillator settle wait wrong");
endmodule // shc_standby_assertions

`default_nettype wire

bind shc_standby_controller shc_standby_assertions #(.PRESCALE_DIV(PRESCALE_DIV),
  .WAIT_PULSES(WAIT_PULSES), .OSC_STAB_CYCLES(OSC_STAB_CYCLES)) u_shc_standby_assertions (
  .clock(clock), .rst_b(rst_b), .instr(instr), .interrupt_request_flag(interrupt_request_flag),
  .source_interrupt_enable(source_interrupt_enable), .timer0_src_is_pin(timer0_src_is_pin),
  .serial_ext_clock(serial_ext_clock), .osc_enable(osc_enable),
  .cpu_clock_enable(cpu_clock_enable), .state_hold(state_hold), .soft_reset_req(soft_reset_req),
  .pins_force_input(pins_force_input), .global_interrupt_enable(global_interrupt_enable),
  .instr_ignored(instr_ignored), .periph(periph), .resume(resume));

// ### tb/shc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

// cpu decoder and interrupt controller seen from the standby block
module shc_cpu_model (
  input  wire logic          clock,
  output shc_pkg::shc_instr_s instr,
  output logic [4:0]         irq,
  output logic [4:0]         ien
);
  // quiet bus at time zero
  initial begin
    instr = '0;
    irq   = 5'h00;
    ien   = 5'h00;
  end

  // nop first, then the standby strobe for one cycle
  task automatic standby(input logic is_stop, input logic [3:0] op, input logic [11:0] addr);
    shc_pkg::shc_instr_s v;
    // built in a local copy so the bus changes once per step
    v = '0;
    v.valid = 1'b1;
    @(posedge clock);
    #1;
    instr = v;
    v.halt = !is_stop;
    v.stop = is_stop;
    v.operand = op;
    v.next_addr = addr;
    @(posedge clock);
    #1;
    instr = v;
    // released fields no longer show the last value
    v = '0;
    v.operand = ~op;
    v.next_addr = ~addr;
    @(posedge clock);
    #1;
    instr = v;
  endtask

  task automatic gie_op(input logic ei, input logic di);
    shc_pkg::shc_instr_s v;
    v = '0;
    v.valid = 1'b1;
    v.ei = ei;
    v.di = di;
    @(posedge clock);
    #1;
    instr = v;
    @(posedge clock);
    #1;
    instr = '0;
  endtask

  task automatic set_irq(input logic [4:0] f, input logic [4:0] e);
    @(posedge clock);
    #1;
    irq = f;
    ien = e;
  endtask
endmodule // shc_cpu_model

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

// standby controller bench with shortened wait counts
module tb;
  logic                 clock;
  logic                 rst_b;
  logic                 t0_pin;
  logic                 ser_ext;
  shc_pkg::shc_instr_s  instr;
  logic [4:0]           irq;
  logic [4:0]           ien;
  logic                 osc_en;
  logic                 cpu_en;
  logic                 hold;
  logic                 soft_rst;
  logic                 pins_in;
  logic                 gie;
  logic                 ignored;
  shc_pkg::shc_periph_s periph;
  shc_pkg::shc_resume_s resume;
  int                   num_errors;
  int                   compares;

  shc_cpu_model u_shc_cpu_model (.clock(clock), .instr(instr), .irq(irq), .ien(ien));

  shc_standby_controller #(.PRESCALE_DIV(4), .WAIT_PULSES(4), .OSC_STAB_CYCLES(8))
    u_shc_standby_controller (
    .clock(clock), .rst_b(rst_b), .instr(instr), .interrupt_request_flag(irq),
    .source_interrupt_enable(ien), .timer0_src_is_pin(t0_pin), .serial_ext_clock(ser_ext),
    .osc_enable(osc_en), .cpu_clock_enable(cpu_en), .state_hold(hold),
    .soft_reset_req(soft_rst), .pins_force_input(pins_in), .global_interrupt_enable(gie),
    .instr_ignored(ignored), .periph(periph), .resume(resume));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // bounded wait for the resume pulse, sampled once the edge has settled
  task automatic wait_res(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      if (resume.valid === 1'b1) return;
    end
    num_errors++;
    $display("[ERR] %0t no resume", $time);
    give_verdict();
  endtask

  task automatic do_reset();
    @(posedge clock);
    #1;
    rst_b = 1'b0;
    repeat (4) @(posedge clock);
    chk_bit(gie, 1'b0, "gie in reset");
    chk_bit(cpu_en, 1'b0, "cpu in reset");
    #1;
    rst_b = 1'b1;
    wait_res(40);
    chk_val(resume.addr, 12'h000, "reset addr");
    chk_val(12'(resume.kind), 12'(shc_pkg::RES_RESET), "reset kind");
  endtask

  task automatic wake(input logic [4:0] f, input logic [4:0] e, input shc_pkg::shc_resume_e k,
                      input logic [11:0] a, input int n);
    u_shc_cpu_model.set_irq(f, e);
    wait_res(n);
    chk_val(12'(resume.kind), 12'(k), "wake kind");
    chk_val(resume.addr, a, "wake addr");
    u_shc_cpu_model.set_irq(5'h00, 5'h00);
  endtask

  initial begin
    num_errors = 0;
    compares = 0;
    rst_b = 1'b0;
    t0_pin = 1'b1;
    ser_ext = 1'b0;
    do_reset();
    $display("test reset done");
    // di wins over ei, then ei alone
    u_shc_cpu_model.gie_op(1'b1, 1'b1);
    chk_bit(gie, 1'b0, "ei with di");
    u_shc_cpu_model.gie_op(1'b1, 1'b0);
    chk_bit(gie, 1'b1, "ei");
    $display("test global enable done");
    // every source alone, then two together, under ei
    for (int i = 0; i < 6; i++) begin
      u_shc_cpu_model.standby(1'b0, 4'h8, 12'h100);
      chk_bit(cpu_en, 1'b0, "halt gates cpu");
      chk_bit(periph.timer1_run & periph.adc_run, 1'b1, "halt keeps peripherals");
      wake((i < 5) ? 5'(1 << i) : 5'h0a, 5'h1f, shc_pkg::RES_VECTOR,
           (i < 5) ? 12'(i + 1) : 12'h004, 4);
    end
    $display("test vectors done");
    u_shc_cpu_model.gie_op(1'b0, 1'b1);
    chk_bit(gie, 1'b0, "di");
    // disabled timer one request does not wake bit three
    u_shc_cpu_model.standby(1'b0, 4'h8, 12'h234);
    u_shc_cpu_model.set_irq(5'h04, 5'h00);
    repeat (10) @(posedge clock);
    chk_bit(cpu_en, 1'b0, "disabled request kept halt");
    wake(5'h04, 5'h04, shc_pkg::RES_SEQUENTIAL, 12'h234, 4);
    u_shc_cpu_model.standby(1'b0, 4'h2, 12'h345);
    wake(5'h04, 5'h00, shc_pkg::RES_SEQUENTIAL, 12'h345, 4);
    $display("test halt wake done");
    // a pending request makes both instructions a nop
    for (int s = 0; s < 2; s++) begin
      u_shc_cpu_model.set_irq(5'h01, 5'h01);
      u_shc_cpu_model.standby(s[0], 4'h8, 12'h010);
      chk_bit(ignored, 1'b1, "ignored pulse");
      chk_bit(cpu_en & osc_en, 1'b1, "stays running");
    end
    u_shc_cpu_model.set_irq(5'h00, 5'h00);
    $display("test nop done");
    u_shc_cpu_model.standby(1'b1, 4'h8, 12'h456);
    chk_bit(osc_en, 1'b0, "stop osc");
    chk_bit(hold, 1'b1, "stop holds state");
    chk_bit(periph.timer0_run, 1'b1, "timer zero on pin");
    chk_bit(periph.serial_run, 1'b0, "serial internal clock");
    chk_bit(periph.timer1_clear & ~periph.timer1_run, 1'b1, "timer one");
    chk_bit(periph.basic_timer_run, 1'b0, "interval timer");
    chk_bit(periph.adc_result_clear & ~periph.adc_run, 1'b1, "converter");
    u_shc_cpu_model.set_irq(5'h04, 5'h00);
    repeat (12) @(posedge clock);
    chk_bit(osc_en, 1'b0, "timer one keeps stop");
    wake(5'h10, 5'h10, shc_pkg::RES_SEQUENTIAL, 12'h456, 20);
    $display("test stop done");
    u_shc_cpu_model.standby(1'b0, 4'h0, 12'h567);
    u_shc_cpu_model.set_irq(5'h1f, 5'h1f);
    repeat (12) @(posedge clock);
    chk_bit(cpu_en, 1'b0, "halt zero stays");
    u_shc_cpu_model.set_irq(5'h00, 5'h00);
    do_reset();
    t0_pin = 1'b0;
    ser_ext = 1'b1;
    u_shc_cpu_model.standby(1'b1, 4'h0, 12'h678);
    chk_bit(soft_rst & pins_in, 1'b1, "stop zero park");
    chk_bit(hold, 1'b0, "stop zero drops retention");
    chk_bit(periph.serial_run, 1'b1, "serial external clock");
    chk_bit(periph.timer0_run, 1'b0, "timer zero on clock");
    do_reset();
    $display("test zero operands done");
    give_verdict();
  end
endmodule // tb

`default_nettype wire
